// ===== logic/mfp_pipeline_front.sv
// MACsec frame pipeline front end: widening, classification, latency, transform
module mfp_pipeline_front (
  input  wire logic         clk,        // 50 MHz clock
  input  wire logic         reset_n,    // Async reset
  input  wire logic         in_valid,   // Input word valid
  input  wire logic [63:0]  in_data,    // Input word
  input  wire logic         in_sof,     // First word of frame
  input  wire logic         in_eof,     // Last word of frame
  input  wire logic [1:0]   in_port,    // Source port
  output logic              in_ready,   // Flow-control feedback
  output logic              out_valid,  // Output word valid
  output logic [127:0]      out_data,   // Output word
  output logic              out_sof,    // First word of frame
  output logic              out_eof,    // Last word of frame
  output logic [1:0]        out_port,   // Source port
  output logic              out_drop,   // Frame to be dropped
  input  wire logic [9:0]   reg_addr,   // Register byte address
  input  wire logic [31:0]  reg_wdata,  // Write data
  input  wire logic         reg_wr,     // Write strobe
  input  wire logic         reg_rd,     // Read strobe
  output logic [31:0]       reg_rdata   // Read data, next cycle
);
  // ==========================================================
  // Registers
  localparam int unsigned N_SA_L = mfp_pkg::N_SA;
  logic [6:0]  ctrl_q;
  logic [7:0]  dflt_q;
  logic [15:0] tpid_q, lat_q, mtug_q;
  logic [6:0]  cofs_q;
  logic [31:0] key_q [8];
  logic [15:0] mtu_q [8];
  logic [25:0] fl_q [N_SA_L];
  logic [16:0] crul_q [mfp_pkg::N_CRUL];
  logic [31:0] npn_q [N_SA_L];
  logic [31:0] lpn_q [N_SA_L];
  logic [31:0] cnt_q [mfp_pkg::N_CNT];

  wire        egress = ctrl_q[0];
  wire        lat_en = ctrl_q[1];
  wire        vbyp   = ctrl_q[2];
  wire        mbyp   = ctrl_q[3];
  wire [2:0]  suite  = ctrl_q[6:4];
  wire [255:0] key   = {key_q[7], key_q[6], key_q[5], key_q[4],
                        key_q[3], key_q[2], key_q[1], key_q[0]};

  wire        wr_key  = reg_wr & (reg_addr[9:5] == mfp_pkg::A_KEY[9:5]);
  wire        wr_mtu  = reg_wr & (reg_addr[9:5] == mfp_pkg::A_MTU[9:5]);
  wire        wr_flow = reg_wr & (reg_addr[9:6] == mfp_pkg::A_FLOW[9:6]);
  wire        wr_crul = reg_wr & (reg_addr[9:7] == mfp_pkg::A_CRUL[9:7])
                      & (reg_addr[6:2] < 5'(mfp_pkg::N_CRUL));
  wire        wr_npn  = reg_wr & (reg_addr[9:6] == mfp_pkg::A_NPN[9:6]);
  wire        wr_lpn  = reg_wr & (reg_addr[9:6] == mfp_pkg::A_LPN[9:6]);

  // ==========================================================
  // Word width upconverter
  logic [63:0] lo_q;
  logic        lo_v_q, lo_sof_q, in_ready_q;
  logic [1:0]  lo_port_q;
  wire         acc     = in_valid & in_ready_q;
  wire         push    = acc & (lo_v_q | in_eof);
  wire [127:0] pk_data = lo_v_q ? {lo_q, in_data} : {in_data, 64'h0};
  wire         pk_sof  = lo_v_q ? lo_sof_q : in_sof;
  wire [1:0]   pk_port = lo_v_q ? lo_port_q : in_port;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_v_q    <= 1'b0;
      lo_q      <= 64'h0;
      lo_sof_q  <= 1'b0;
      lo_port_q <= 2'h0;
    end else if (acc) begin
      lo_v_q    <= ~lo_v_q & ~in_eof;
      lo_q      <= in_data;
      lo_sof_q  <= in_sof;
      lo_port_q <= in_port;
    end
  end

  // ==========================================================
  // Word FIFO with arrival time stamps
  logic [127:0] f_data [mfp_pkg::FIFO_D];
  logic         f_sof  [mfp_pkg::FIFO_D];
  logic         f_eof  [mfp_pkg::FIFO_D];
  logic [1:0]   f_port [mfp_pkg::FIFO_D];
  logic [15:0]  f_ts   [mfp_pkg::FIFO_D];
  logic [2:0]   wp_q, rp_q;
  logic [3:0]   fcnt_q;
  logic [15:0]  ts_q;
  wire          empty = (fcnt_q == 4'h0);
  wire [127:0]  hd    = f_data[rp_q];
  wire [15:0]   age   = ts_q - f_ts[rp_q];
  wire          hold  = lat_en & f_sof[rp_q] & (age < lat_q);
  wire          pop   = ~empty & ~hold;
  wire [3:0]    fcnt_d = fcnt_q + {3'h0, push} - {3'h0, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      f_data[wp_q] <= pk_data;
      f_sof[wp_q]  <= pk_sof;
      f_eof[wp_q]  <= in_eof;
      f_port[wp_q] <= pk_port;
      f_ts[wp_q]   <= ts_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q       <= 3'h0;
      rp_q       <= 3'h0;
      fcnt_q     <= 4'h0;
      ts_q       <= 16'h0;
      in_ready_q <= 1'b0;
    end else begin
      wp_q       <= wp_q + {2'h0, push};
      rp_q       <= rp_q + {2'h0, pop};
      fcnt_q     <= fcnt_d;
      ts_q       <= ts_q + 16'h1;
      in_ready_q <= (fcnt_d <= mfp_pkg::FIFO_HI);
    end
  end
  assign in_ready = in_ready_q;

  // ==========================================================
  // Classification of the head word
  wire [15:0] et      = hd[31:16];
  wire [7:0]  tci     = hd[15:8];
  wire        is_vlan = (et == tpid_q);
  wire        is_mpls = (et == mfp_pkg::ET_MPLS);
  wire        bad_tci = tci[7] | (tci[6] & tci[5]) | (tci[5] & tci[4]);
  wire mfp_pkg::mfp_tag_t tc = (et == mfp_pkg::ET_KAY) ? mfp_pkg::TC_KAY :
                           (et != mfp_pkg::ET_MACSEC) ? mfp_pkg::TC_UNTAG :
                           bad_tci ? mfp_pkg::TC_BAD : mfp_pkg::TC_TAGGED;
  logic [mfp_pkg::N_CRUL-1:0] cr_hit;
  logic [N_SA_L-1:0]          fl_hit;
  genvar gi;
  generate
    for (gi = 0; gi < mfp_pkg::N_CRUL; gi++) begin : g_crul
      assign cr_hit[gi] = crul_q[gi][16] & (crul_q[gi][15:0] == et);
    end
    for (gi = 0; gi < N_SA_L; gi++) begin : g_flow
      assign fl_hit[gi] = fl_q[gi][22] & (fl_q[gi][15:0] == et)
                        & (~fl_q[gi][25] | (fl_q[gi][24:23] == tc));
    end
  endgenerate
  wire        is_ctrl  = |cr_hit;
  wire [2:0]  cls      = {tc, is_ctrl};
  logic       best_v;
  logic [3:0] best_i, best_p;
  always_comb begin
    best_v = 1'b0;
    best_i = 4'h0;
    best_p = 4'h0;
    for (int i = 0; i < N_SA_L; i++) begin
      if (fl_hit[i] && (!best_v || fl_q[i][21:18] > best_p)) begin
        best_v = 1'b1;
        best_i = 4'(i);
        best_p = fl_q[i][21:18];
      end
    end
  end
  wire mfp_pkg::mfp_act_t dflt_act = dflt_q[cls] ? mfp_pkg::ACT_BYP : mfp_pkg::ACT_DROP;
  wire mfp_pkg::mfp_act_t new_act  = best_v ? mfp_pkg::mfp_act_t'(fl_q[best_i][17:16])
                                            : dflt_act;
  wire [15:0] new_lim   = is_vlan ? mtu_q[hd[15:13]] : mtug_q;
  wire [10:0] new_start = mfp_pkg::HDR_BYTES + {4'h0, cofs_q}
                        + ((vbyp & is_vlan) ? mfp_pkg::TAG_BYTES : 11'h0)
                        + ((mbyp & is_mpls) ? mfp_pkg::TAG_BYTES : 11'h0)
                        + (egress ? 11'h0 : mfp_pkg::SEC_BYTES);

  // ==========================================================
  // Frame token and per-word transform
  mfp_pkg::mfp_state_t st_q;
  mfp_pkg::mfp_act_t   act_q;
  logic [3:0]  sa_q;
  logic [15:0] lim_q, len_q;
  logic [10:0] start_q;
  logic [6:0]  wi_q;
  logic        drop_q;
  logic [31:0] pn_q;

  wire        sofp    = pop & f_sof[rp_q] & (st_q == mfp_pkg::ST_IDLE);
  wire mfp_pkg::mfp_act_t cur_act = sofp ? new_act : act_q;
  wire [3:0]  cur_sa  = sofp ? best_i : sa_q;
  wire [10:0] cur_st  = sofp ? new_start : start_q;
  wire [6:0]  cur_wi  = sofp ? 7'h0 : wi_q;
  wire [15:0] cur_len = (sofp ? 16'h0 : len_q) + mfp_pkg::WORD_BYTES;
  wire [15:0] cur_lim = sofp ? new_lim : lim_q;
  wire        is_sec  = (cur_act == mfp_pkg::ACT_SEC);
  wire        pn_word = ~egress & ~sofp & (wi_q == 7'h1);
  wire [31:0] rx_pn   = hd[127:96];
  wire        late    = pop & is_sec & pn_word & (rx_pn < lpn_q[sa_q]);
  wire        over    = cur_len > cur_lim;
  wire [31:0] cur_pn  = sofp ? (egress ? npn_q[best_i] : 32'h0) :
                        pn_word ? rx_pn : pn_q;
  wire        cur_drop = (sofp ? (new_act == mfp_pkg::ACT_DROP) : drop_q) | late | over;
  wire        wide   = (suite == mfp_pkg::SU_GCM256) | (suite == mfp_pkg::SU_XPN256);
  wire        do_enc = is_sec & (suite != mfp_pkg::SU_GMAC);
  wire        no_ctr = (suite == mfp_pkg::SU_ECB);
  wire [127:0] ctr_blk = no_ctr ? 128'h0 : {cur_pn, 25'h0, cur_wi, cur_pn, 32'h0};
  wire [127:0] ks = key[127:0] ^ {ctr_blk[95:0], ctr_blk[127:96]}
                  ^ (wide ? key[255:128] : 128'h0);
  logic [127:0] msk;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_byte
      wire [10:0] pos = {cur_wi, 4'h0} + 11'(gi);
      assign msk[127-8*gi -: 8] = {8{do_enc & (pos >= cur_st)}};
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= mfp_pkg::ST_IDLE;
      act_q   <= mfp_pkg::ACT_DROP;
      sa_q    <= 4'h0;
      lim_q   <= 16'h0;
      len_q   <= 16'h0;
      start_q <= 11'h0;
      wi_q    <= 7'h0;
      drop_q  <= 1'b0;
      pn_q    <= 32'h0;
    end else if (pop) begin
      act_q   <= cur_act;
      sa_q    <= cur_sa;
      lim_q   <= cur_lim;
      len_q   <= cur_len;
      start_q <= cur_st;
      wi_q    <= cur_wi + 7'h1;
      drop_q  <= cur_drop;
      pn_q    <= cur_pn;
      case (st_q)
        mfp_pkg::ST_IDLE: st_q <= (f_sof[rp_q] & ~f_eof[rp_q]) ? mfp_pkg::ST_BODY : st_q;
        mfp_pkg::ST_BODY: st_q <= f_eof[rp_q] ? mfp_pkg::ST_IDLE : st_q;
        default:          st_q <= mfp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data  <= 128'h0;
      out_sof   <= 1'b0;
      out_eof   <= 1'b0;
      out_port  <= 2'h0;
      out_drop  <= 1'b0;
    end else begin
      out_valid <= pop;
      out_data  <= hd ^ (ks & msk);
      out_sof   <= sofp;
      out_eof   <= f_eof[rp_q];
      out_port  <= f_port[rp_q];
      out_drop  <= cur_drop | ~(sofp | (st_q == mfp_pkg::ST_BODY));
    end
  end

  // ==========================================================
  // Register writes, packet numbers and statistics
  wire eof_pop = pop & f_eof[rp_q];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 7'h0;
      dflt_q <= 8'h0;
      tpid_q <= mfp_pkg::TPID_RST;
      lat_q  <= 16'h0;
      cofs_q <= 7'h0;
      mtug_q <= mfp_pkg::MTU_RST;
      for (int i = 0; i < 8; i++) begin
        key_q[i] <= 32'h0;
        mtu_q[i] <= mfp_pkg::MTU_RST;
      end
      for (int i = 0; i < N_SA_L; i++) begin
        fl_q[i]  <= 26'h0;
        npn_q[i] <= 32'h0;
        lpn_q[i] <= 32'h0;
      end
      for (int i = 0; i < mfp_pkg::N_CRUL; i++) crul_q[i] <= 17'h0;
      for (int i = 0; i < mfp_pkg::N_CNT; i++) cnt_q[i] <= 32'h0;
    end else begin
      if (sofp && egress && is_sec) npn_q[best_i] <= npn_q[best_i] + 32'h1;
      if (pop && is_sec && pn_word && !late) lpn_q[sa_q] <= rx_pn + 32'h1;
      if (late) cnt_q[mfp_pkg::C_LATE] <= cnt_q[mfp_pkg::C_LATE] + 32'h1;
      if (eof_pop) begin
        cnt_q[mfp_pkg::C_IN] <= cnt_q[mfp_pkg::C_IN] + 32'h1;
        if (cur_drop) cnt_q[mfp_pkg::C_DROP] <= cnt_q[mfp_pkg::C_DROP] + 32'h1;
        else if (is_sec) cnt_q[mfp_pkg::C_SEC] <= cnt_q[mfp_pkg::C_SEC] + 32'h1;
        else cnt_q[mfp_pkg::C_BYP] <= cnt_q[mfp_pkg::C_BYP] + 32'h1;
      end
      if (reg_wr && reg_addr == mfp_pkg::A_CTRL) ctrl_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == mfp_pkg::A_DFLT) dflt_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == mfp_pkg::A_TPID) tpid_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == mfp_pkg::A_LAT)  lat_q  <= reg_wdata[15:0];
      if (reg_wr && reg_addr == mfp_pkg::A_COFS) cofs_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == mfp_pkg::A_MTUG) mtug_q <= reg_wdata[15:0];
      if (wr_key)  key_q[reg_addr[4:2]]  <= reg_wdata;
      if (wr_mtu)  mtu_q[reg_addr[4:2]]  <= reg_wdata[15:0];
      if (wr_flow) fl_q[reg_addr[5:2]]   <= reg_wdata[25:0];
      if (wr_crul) crul_q[reg_addr[6:2]] <= reg_wdata[16:0];
      if (wr_npn)  npn_q[reg_addr[5:2]]  <= reg_wdata;
      if (wr_lpn)  lpn_q[reg_addr[5:2]]  <= reg_wdata;
    end
  end

  // ==========================================================
  // Read data
  wire [2:0]  cnt_i = reg_addr[4:2];
  wire [31:0] rd_w =
    (reg_addr == mfp_pkg::A_CTRL) ? {25'h0, ctrl_q} :
    (reg_addr == mfp_pkg::A_DFLT) ? {24'h0, dflt_q} :
    (reg_addr == mfp_pkg::A_TPID) ? {16'h0, tpid_q} :
    (reg_addr == mfp_pkg::A_LAT)  ? {16'h0, lat_q} :
    (reg_addr == mfp_pkg::A_COFS) ? {25'h0, cofs_q} :
    (reg_addr == mfp_pkg::A_MTUG) ? {16'h0, mtug_q} :
    (reg_addr == mfp_pkg::A_STAT) ? {25'h0, in_ready_q, fcnt_q, st_q, lo_v_q} :
    (reg_addr[9:5] == mfp_pkg::A_KEY[9:5])  ? key_q[reg_addr[4:2]] :
    (reg_addr[9:5] == mfp_pkg::A_MTU[9:5])  ? {16'h0, mtu_q[reg_addr[4:2]]} :
    (reg_addr[9:6] == mfp_pkg::A_FLOW[9:6]) ? {6'h0, fl_q[reg_addr[5:2]]} :
    wr_crul | (reg_rd & (reg_addr[9:7] == mfp_pkg::A_CRUL[9:7])
               & (reg_addr[6:2] < 5'(mfp_pkg::N_CRUL))) ? {15'h0, crul_q[reg_addr[6:2]]} :
    (reg_addr[9:6] == mfp_pkg::A_NPN[9:6])  ? npn_q[reg_addr[5:2]] :
    (reg_addr[9:6] == mfp_pkg::A_LPN[9:6])  ? lpn_q[reg_addr[5:2]] :
    ((reg_addr[9:5] == mfp_pkg::A_CNT[9:5]) & (cnt_i < 3'(mfp_pkg::N_CNT))) ? cnt_q[cnt_i] :
    32'h0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 32'h0;
    else reg_rdata <= reg_rd ? rd_w : 32'h0;
  end

  // ==========================================================
  // Assertions
  logic [31:0] npn_sel;
  assign npn_sel = npn_q[best_i];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ready_room: assert property (in_ready |-> fcnt_q <= mfp_pkg::FIFO_HI)
    else $error("ready raised with FIFO too full");
  a_fifo_no_ovf: assert property (push |-> fcnt_q < 4'h8 || pop)
    else $error("FIFO written while full");
  a_lat_hold: assert property (pop && f_sof[rp_q] && lat_en |-> age >= lat_q)
    else $error("first word left before target latency");
  a_pn_step: assert property (sofp && egress && is_sec && !reg_wr
      |=> npn_q[$past(best_i)] == $past(npn_sel) + 32'h1)
    else $error("next packet number not advanced");
  a_late_drop: assert property (late |=> out_valid && out_drop)
    else $error("late packet number not dropped");
  a_over_drop: assert property (pop && over |=> out_drop)
    else $error("oversize frame not dropped");
  a_default_act: assert property (sofp && !best_v |-> new_act == dflt_act)
    else $error("default action not used on miss");
  a_pack_pair: assert property (push && lo_v_q
      |-> pk_data[127:64] == lo_q && pk_sof == lo_sof_q)
    else $error("word pair packed wrongly");
  a_frame_order: assert property (out_valid && out_sof |=> !out_valid || !out_sof
      || $past(out_eof))
    else $error("frames interleaved");
endmodule // mfp_pipeline_front

// ===== include/mfp_pkg.sv
// Constants and types of the MACsec frame pipeline front end
package mfp_pkg;
  // Register byte addresses
  localparam logic [9:0] A_CTRL = 10'h000;
  localparam logic [9:0] A_DFLT = 10'h004;
  localparam logic [9:0] A_TPID = 10'h008;
  localparam logic [9:0] A_LAT  = 10'h00c;
  localparam logic [9:0] A_COFS = 10'h010;
  localparam logic [9:0] A_MTUG = 10'h014;
  localparam logic [9:0] A_STAT = 10'h018;
  localparam logic [9:0] A_KEY  = 10'h020;
  localparam logic [9:0] A_MTU  = 10'h040;
  localparam logic [9:0] A_FLOW = 10'h080;
  localparam logic [9:0] A_CRUL = 10'h100;
  localparam logic [9:0] A_NPN  = 10'h180;
  localparam logic [9:0] A_LPN  = 10'h1c0;
  localparam logic [9:0] A_CNT  = 10'h200;
  // Sizes
  localparam int unsigned N_SA   = 16;
  localparam int unsigned N_CRUL = 29;
  localparam int unsigned N_CLS  = 8;
  localparam int unsigned N_CNT  = 5;
  localparam int unsigned FIFO_D = 8;
  localparam logic [3:0]  FIFO_HI = 4'h5;
  // Reset values and EtherTypes
  localparam logic [15:0] TPID_RST = 16'h8100;
  localparam logic [15:0] MTU_RST  = 16'h05f2;
  localparam logic [15:0] ET_MACSEC = 16'h88e5;
  localparam logic [15:0] ET_KAY    = 16'h888e;
  localparam logic [15:0] ET_MPLS   = 16'h8847;
  // Byte counts of headers and of one word
  localparam logic [10:0] HDR_BYTES = 11'h00c;
  localparam logic [10:0] TAG_BYTES = 11'h004;
  localparam logic [10:0] SEC_BYTES = 11'h008;
  localparam logic [15:0] WORD_BYTES = 16'h0010;
  // Counter indexes
  localparam logic [2:0] C_IN = 3'h0;
  localparam logic [2:0] C_DROP = 3'h1;
  localparam logic [2:0] C_BYP = 3'h2;
  localparam logic [2:0] C_SEC = 3'h3;
  localparam logic [2:0] C_LATE = 3'h4;

  typedef enum logic [2:0] {
    SU_GCM128 = 3'b000, SU_GCM256 = 3'b001, SU_XPN128 = 3'b010, SU_XPN256 = 3'b011,
    SU_ECB = 3'b100, SU_CTR = 3'b101, SU_GMAC = 3'b110, SU_RSV = 3'b111
  } mfp_suite_t;
  typedef enum logic [1:0] {
    ACT_DROP = 2'b00, ACT_BYP = 2'b01, ACT_SEC = 2'b10, ACT_RSV = 2'b11
  } mfp_act_t;
  typedef enum logic [1:0] {
    TC_UNTAG = 2'b00, TC_TAGGED = 2'b01, TC_BAD = 2'b10, TC_KAY = 2'b11
  } mfp_tag_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_BODY = 1'b1} mfp_state_t;
endpackage

// ===== test/mfp_src_model.sv
// Upstream flow-control buffer that feeds 64-bit words to the front end
module mfp_src_model (
  input  wire logic        clk,       // Clock
  input  wire logic        reset_n,   // Async reset
  input  wire logic        in_ready,  // Feedback from block
  output logic             in_valid,  // Word valid
  output logic [63:0]      in_data,   // Word
  output logic             in_sof,    // First word
  output logic             in_eof,    // Last word
  output logic [1:0]       in_port    // Source port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [67:0] q[$];
  logic        slow = 1'b0;
  task automatic push(input logic [67:0] e);
    q.push_back(e);
  endtask
  // Word held until taken; idle data keeps toggling
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_valid <= 1'b0;
      in_data  <= 64'h0;
      in_sof   <= 1'b0;
      in_eof   <= 1'b0;
      in_port  <= 2'h0;
    end else if (!in_valid || in_ready) begin
      if (q.size() != 0 && !(slow && $urandom_range(1) == 0)) begin
        {in_port, in_sof, in_eof, in_data} <= q.pop_front();
        in_valid <= 1'b1;
      end else begin
        in_valid <= 1'b0;
        in_data  <= ~in_data;
        in_sof   <= 1'b0;
        in_eof   <= 1'b0;
      end
    end
  end
endmodule // mfp_src_model

// ===== test/tb_top.sv
// Self-checking bench of the frame pipeline front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, in_valid, in_sof, in_eof, in_ready;
  logic out_valid, out_sof, out_eof, out_drop, reg_wr, reg_rd;
  logic [63:0]  in_data;
  logic [127:0] out_data;
  logic [1:0]   in_port, out_port;
  logic [9:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  logic [133:0] expq[$];
  logic [133:0] e;
  logic [15:0]  et;
  logic [2:0]   cls;
  logic         saw_low;
  int mismatches, checks_done, cycles, t_in, t_out, n_frames, n_drops;
  mfp_pipeline_front u_mfp_pipeline_front (.clk(clk), .reset_n(reset_n),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof), .in_eof(in_eof),
    .in_port(in_port), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_sof(out_sof), .out_eof(out_eof), .out_port(out_port), .out_drop(out_drop),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  mfp_src_model u_mfp_src_model (.clk(clk), .reset_n(reset_n), .in_ready(in_ready),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof), .in_eof(in_eof),
    .in_port(in_port));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk_out(input string n, input logic [127:0] x, input logic [127:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg("reg_rdata", x, reg_rdata);
  endtask
  // Queue one frame and its expected 128-bit words
  task automatic send(input logic [15:0] t, input int n, input logic dr);
    logic [63:0] w [0:15];
    logic [1:0]  p;
    p = 2'($urandom);
    n_frames++;
    if (dr) n_drops++;
    for (int i = 0; i < n; i++) w[i] = {$urandom, $urandom};
    w[1][31:16] = t;
    for (int i = 0; i < n; i++) u_mfp_src_model.push({p, 1'(i == 0), 1'(i == n - 1), w[i]});
    for (int i = 0; i < n; i += 2)
      expq.push_back({!dr, dr, p, 1'(i == 0), 1'(i + 2 >= n), w[i],
                      (i + 1 < n) ? w[i + 1] : 64'h0});
  endtask
  task automatic frame(input logic [15:0] t, input int n, input logic dr);
    send(t, n, dr);
    for (int i = 0; i < 400 && expq.size() != 0; i++) @(posedge clk);
    chk_out("pending words", 128'h0, 128'(expq.size()));
  endtask
  always @(negedge clk) begin
    if (in_valid && in_ready && in_sof) t_in = cycles;
    if (out_valid && out_sof) t_out = cycles;
    if (cycles > 10 && in_ready === 1'b0) saw_low = 1'b1;
    if (reset_n && out_valid === 1'b1) begin
      if (expq.size() == 0) chk_out("extra word", 128'h0, 128'h1);
      else begin
        e = expq.pop_front();
        chk_out("framing", 128'(e[131:128]), 128'({out_port, out_sof, out_eof}));
        if (e[133]) chk_out("out_data", e[127:0], out_data);
        if (e[128]) chk_out("out_drop", 128'(e[132]), 128'(out_drop));
      end
    end
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 10'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(83));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(mfp_pkg::A_TPID, {16'h0, mfp_pkg::TPID_RST});
    rd(mfp_pkg::A_MTUG, {16'h0, mfp_pkg::MTU_RST});
    rd(mfp_pkg::A_DFLT, 32'h0);
    wr(10'h3fc, 32'h5a5a);
    rd(10'h3fc, 32'h0);
    wr(mfp_pkg::A_DFLT, 32'hff);
    rd(mfp_pkg::A_DFLT, 32'hff);
    u_mfp_src_model.slow = 1'b1;
    repeat (8) send(16'h0800, 2 + int'($urandom_range(9)), 1'b0);
    frame(16'h0800, 3, 1'b0);
    u_mfp_src_model.slow = 1'b0;
    for (int k = 0; k < 4; k++) begin
      et = k[1] ? mfp_pkg::ET_KAY : 16'h0800;
      cls = {k[1], k[1], k[0]};
      wr(mfp_pkg::A_CRUL, {15'h0, k[0], et});
      wr(mfp_pkg::A_DFLT, 32'(8'h01 << cls));
      frame(et, 4, 1'b0);
      wr(mfp_pkg::A_DFLT, 32'(~(8'h01 << cls)));
      frame(et, 4, 1'b1);
    end
    wr(mfp_pkg::A_CRUL, 32'h0);
    wr(mfp_pkg::A_DFLT, 32'hff);
    wr(mfp_pkg::A_FLOW, 32'h0044_0800);
    frame(16'h0800, 4, 1'b1);
    wr(mfp_pkg::A_DFLT, 32'h0);
    wr(mfp_pkg::A_FLOW + 10'h4, 32'h0049_0800);
    frame(16'h0800, 4, 1'b0);
    wr(mfp_pkg::A_FLOW, 32'h0);
    wr(mfp_pkg::A_FLOW + 10'h4, 32'h0);
    wr(mfp_pkg::A_DFLT, 32'hff);
    wr(mfp_pkg::A_MTUG, 32'h20);
    frame(16'h0800, 4, 1'b0);
    frame(16'h0800, 6, 1'b1);
    wr(mfp_pkg::A_MTUG, {16'h0, mfp_pkg::MTU_RST});
    wr(mfp_pkg::A_LAT, 32'd40);
    wr(mfp_pkg::A_CTRL, 32'h3);
    saw_low = 1'b0;
    frame(16'h0800, 16, 1'b0);
    chk_out("latency", 128'h1, 128'(t_out - t_in >= 40));
    chk_out("ready low", 128'h1, 128'(saw_low));
    chk_out("latency max", 128'h1, 128'(t_out - t_in <= 44));
    // Ingress secure flow with a stale packet number must be dropped
    wr(mfp_pkg::A_CTRL, 32'h0);
    wr(mfp_pkg::A_FLOW, 32'h0046_0800);
    wr(mfp_pkg::A_LPN, 32'hffff_ffff);
    frame(16'h0800, 4, 1'b1);
    rd(mfp_pkg::A_CNT, 32'(n_frames));
    rd(mfp_pkg::A_CNT + 10'h4, 32'(n_drops));
    rd(mfp_pkg::A_CNT + 10'h8, 32'(n_frames - n_drops));
    rd(mfp_pkg::A_CNT + 10'hc, 32'h0);
    rd(mfp_pkg::A_CNT + 10'h10, 32'h1);
    rd(mfp_pkg::A_LPN, 32'hffff_ffff);
    test_done();
  end
endmodule // tb_top
